// ### rtl/crb_irq.sv
`timescale 1ns/1ps
module crb_irq #(
  parameter int N = 3
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [N-1:0] events,
  input wire logic [N-1:0] holdSet,
  input wire logic clrWe,
  input wire logic maskWe,
  input wire logic [N-1:0] wrData,
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);

  logic [N-1:0] status_ff;
  logic [N-1:0] mask_ff;
  logic irq_ff;
  logic [N-1:0] clrBits;

  assign clrBits = clrWe ? wrData : '0;

  // Write one clears; an event or a standing condition sets again
  always_ff @(posedge clk) begin
    if (reset) begin
      status_ff <= '0;
    end else begin
      status_ff <= (status_ff & ~clrBits) | events | (clrBits & holdSet);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mask_ff <= '0;
    end else if (maskWe) begin
      mask_ff <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(((status_ff & ~clrBits) | events | (clrBits & holdSet))
        & (maskWe ? wrData : mask_ff));
    end
  end

  assign status = status_ff;
  assign mask = mask_ff;
  assign irq = irq_ff;

  a_reflag_full: assert property (@(posedge clk) disable iff (reset)
    (clrBits[0] && holdSet[0]) |=> status_ff[0])
    else $error("Receive flag not set again while buffer full");

  a_irq_level: assert property (@(posedge clk) disable iff (reset)
    ##1 irq_ff == |(status_ff & mask_ff))
    else $error("Interrupt output disagrees with status and mask");

endmodule // crb_irq

// ### rtl/crb_pkg.sv
package crb_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL0 = 5'h00;
  localparam logic [4:0] OFS_CTRL1 = 5'h04;
  localparam logic [4:0] OFS_DLC0 = 5'h08;
  localparam logic [4:0] OFS_DLC1 = 5'h0C;
  localparam logic [4:0] OFS_MODE = 5'h10;
  localparam logic [4:0] OFS_STAT = 5'h14;
  localparam logic [4:0] OFS_MASK = 5'h18;

  // Field positions
  localparam int BIT_FULL = 7;
  localparam int BIT_RTR = 6;
  localparam int BIT_DBEN = 2;
  localparam int BIT_JUMP_TABLE_OFFSET_COPY = 1;
  localparam int BIT_FHLSB = 0;

  localparam int CODE_W = 5;
  localparam int FILT_W = 4;
  localparam int DLC_W = 4;

  // Event bits of status and mask
  localparam int EV_RX0 = 0;
  localparam int EV_RX1 = 1;
  localparam int EV_OVF = 2;
  localparam int EV_W = 3;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h00000000;

  typedef enum logic [1:0] {
    CRB_MODE_LEGACY = 2'h0,
    CRB_MODE_ENH1 = 2'h1,
    CRB_MODE_ENH2 = 2'h2
  } crb_mode_e;

  function automatic logic crb_is_enhanced(input logic [1:0] mode);
    crb_is_enhanced = (mode != CRB_MODE_LEGACY);
  endfunction

endpackage

// ### rtl/crb_receive_status.sv
`timescale 1ns/1ps
// Summary of operation
// - No overflow into buffer 1 unless enabled
// - Legacy bit 1 mirrors double-buffer enable
// - Legacy bit 0 names filter 0 or 1
// - Enhanced modes show five-bit filter code
// - Full flag set on store, blocks loads
// - Clearing interrupt while full sets it again
// - Length register bits 7,5,4 read zero
// - Length register shows code and remote flag
module crb_receive_status (
  input wire logic clk,
  input wire logic reset,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic rxValid,
  input wire logic [crb_pkg::FILT_W-1:0] rxFilter,
  input wire logic [crb_pkg::DLC_W-1:0] rxDlc,
  input wire logic remote_request_flag,
  output logic irq
);

  logic waitrequest_ff;
  logic [31:0] readdata_ff;
  logic [1:0] mode_ff;
  logic dben_ff;
  logic enhanced;
  logic accept;
  logic wrLane;
  logic load0;
  logic load1;
  logic overflow;
  logic clrFull0;
  logic clrFull1;
  logic full0;
  logic full1;
  logic rtr0;
  logic rtr1;
  logic [crb_pkg::FILT_W-1:0] filt0;
  logic [crb_pkg::FILT_W-1:0] filt1;
  logic [crb_pkg::DLC_W-1:0] dlc0;
  logic [crb_pkg::DLC_W-1:0] dlc1;
  logic [crb_pkg::EV_W-1:0] events;
  logic [crb_pkg::EV_W-1:0] holdSet;
  logic [crb_pkg::EV_W-1:0] status;
  logic [crb_pkg::EV_W-1:0] mask;
  logic [7:0] ctrl0View;
  logic [7:0] ctrl1View;
  logic [7:0] dlc0View;
  logic [7:0] dlc1View;
  logic [7:0] rdByte;

  function automatic logic [7:0] dlc_view(input logic rtr, input logic [3:0] code);
    logic [7:0] v;
    v = crb_pkg::RST_BYTE; // Bits 7, 5, 4 stay zero
    v[crb_pkg::BIT_RTR] = rtr;
    v[crb_pkg::DLC_W-1:0] = code;
    dlc_view = v;
  endfunction

  // Bus access is taken in the cycle that waitrequest is low
  assign accept = (read | write) & ~waitrequest_ff;
  assign wrLane = accept & write & byteenable[0];
  assign enhanced = crb_pkg::crb_is_enhanced(mode_ff);

  // Frame steering
  always_comb begin
    load0 = 1'b0;
    load1 = 1'b0;
    overflow = 1'b0;
    if (rxValid) begin
      if (!full0) begin
        load0 = 1'b1;
      end else if (dben_ff && !full1) begin
        load1 = 1'b1;
      end else begin
        overflow = 1'b1;
      end
    end
  end

  // Software clears a full flag by writing zero to it
  assign clrFull0 = wrLane && address == crb_pkg::OFS_CTRL0
    && !writedata[crb_pkg::BIT_FULL];
  assign clrFull1 = wrLane && address == crb_pkg::OFS_CTRL1
    && !writedata[crb_pkg::BIT_FULL];

  crb_slot u_slot0 (
    .clk(clk),
    .reset(reset),
    .load(load0),
    .clearFull(clrFull0),
    .loadFilter(rxFilter),
    .loadDlc(rxDlc),
    .loadRtr(remote_request_flag),
    .full(full0),
    .filter(filt0),
    .dlc(dlc0),
    .rtr(rtr0)
  );

  crb_slot u_slot1 (
    .clk(clk),
    .reset(reset),
    .load(load1),
    .clearFull(clrFull1),
    .loadFilter(rxFilter),
    .loadDlc(rxDlc),
    .loadRtr(remote_request_flag),
    .full(full1),
    .filter(filt1),
    .dlc(dlc1),
    .rtr(rtr1)
  );

  always_comb begin
    events = '0;
    events[crb_pkg::EV_RX0] = load0;
    events[crb_pkg::EV_RX1] = load1;
    events[crb_pkg::EV_OVF] = overflow;
    holdSet = '0;
    holdSet[crb_pkg::EV_RX0] = full0 & ~clrFull0;
    holdSet[crb_pkg::EV_RX1] = full1 & ~clrFull1;
  end

  crb_irq #(
    .N(crb_pkg::EV_W)
  ) u_irq (
    .clk(clk),
    .reset(reset),
    .events(events),
    .holdSet(holdSet),
    .clrWe(wrLane && address == crb_pkg::OFS_STAT),
    .maskWe(wrLane && address == crb_pkg::OFS_MASK),
    .wrData(writedata[crb_pkg::EV_W-1:0]),
    .status(status),
    .mask(mask),
    .irq(irq)
  );

  // Mode register
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_ff <= crb_pkg::CRB_MODE_LEGACY;
    end else if (wrLane && address == crb_pkg::OFS_MODE) begin
      mode_ff <= writedata[1:0];
    end
  end

  // Double-buffer enable is writable in legacy mode only
  always_ff @(posedge clk) begin
    if (reset) begin
      dben_ff <= 1'b0;
    end else if (wrLane && address == crb_pkg::OFS_CTRL0 && !enhanced) begin
      dben_ff <= writedata[crb_pkg::BIT_DBEN];
    end
  end

  // Control views
  always_comb begin
    ctrl0View = crb_pkg::RST_BYTE;
    ctrl0View[crb_pkg::BIT_FULL] = full0;
    if (enhanced) begin
      ctrl0View[crb_pkg::CODE_W-1:0] = {1'b0, filt0};
    end else begin
      ctrl0View[crb_pkg::BIT_DBEN] = dben_ff;
      ctrl0View[crb_pkg::BIT_JUMP_TABLE_OFFSET_COPY] = dben_ff;
      ctrl0View[crb_pkg::BIT_FHLSB] = filt0[0];
    end
    ctrl1View = crb_pkg::RST_BYTE;
    ctrl1View[crb_pkg::BIT_FULL] = full1;
    ctrl1View[crb_pkg::CODE_W-1:0] = {1'b0, filt1};
  end

  assign dlc0View = dlc_view(rtr0, dlc0);
  assign dlc1View = dlc_view(rtr1, dlc1);

  // Read decode, unmapped reads give zero
  always_comb begin
    case (address)
      crb_pkg::OFS_CTRL0: rdByte = ctrl0View;
      crb_pkg::OFS_CTRL1: rdByte = ctrl1View;
      crb_pkg::OFS_DLC0: rdByte = dlc0View;
      crb_pkg::OFS_DLC1: rdByte = dlc1View;
      crb_pkg::OFS_MODE: rdByte = {6'h00, mode_ff};
      crb_pkg::OFS_STAT: rdByte = {5'h00, status};
      crb_pkg::OFS_MASK: rdByte = {5'h00, mask};
      default: rdByte = crb_pkg::RST_BYTE;
    endcase
  end

  // One wait cycle per access
  always_ff @(posedge clk) begin
    if (reset) begin
      waitrequest_ff <= 1'b1;
    end else begin
      waitrequest_ff <= ~((read | write) & waitrequest_ff);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      readdata_ff <= crb_pkg::RST_WORD;
    end else if (read && waitrequest_ff) begin
      readdata_ff <= {24'h000000, rdByte};
    end
  end

  assign readdata = readdata_ff;
  assign waitrequest = waitrequest_ff;

  sequence s_legacy_store;
    load0 && !enhanced;
  endsequence

  sequence s_legacy_overflow;
    rxValid && full0 && !dben_ff;
  endsequence

  a_no_pass_over: assert property (@(posedge clk) disable iff (reset)
    s_legacy_overflow |-> !load1 && overflow)
    else $error("Frame passed into buffer 1 with double buffering off");

  a_offset_copy: assert property (@(posedge clk) disable iff (reset)
    !enhanced |-> ctrl0View[crb_pkg::BIT_JUMP_TABLE_OFFSET_COPY] == dben_ff)
    else $error("Jump table copy differs from enable");

  a_hit_lsb: assert property (@(posedge clk) disable iff (reset)
    s_legacy_store ##1 !enhanced |->
      ctrl0View[crb_pkg::BIT_FHLSB] == $past(rxFilter[0]))
    else $error("Filter hit bit does not match accepting filter");

  a_hit_code: assert property (@(posedge clk) disable iff (reset)
    load0 ##1 enhanced |-> ctrl0View[4:0] == {1'b0, $past(rxFilter)})
    else $error("Filter hit code wrong in enhanced mode");

  a_full_on_store: assert property (@(posedge clk) disable iff (reset)
    load0 |=> full0 ##1 (full0 || $past(clrFull0)))
    else $error("Full flag not set after store");

  a_reflag_stat: assert property (@(posedge clk) disable iff (reset)
    (wrLane && address == crb_pkg::OFS_STAT && writedata[0] && full0 && !clrFull0)
      |=> status[crb_pkg::EV_RX0])
    else $error("Receive flag cleared while buffer still full");

  a_dlc_zeros: assert property (@(posedge clk) disable iff (reset)
    dlc0View[7] == 1'b0 && dlc0View[5:4] == 2'h0 && dlc1View[7] == 1'b0)
    else $error("Reserved length bits not zero");

  a_dlc_report: assert property (@(posedge clk) disable iff (reset)
    load0 |=> dlc0View[3:0] == $past(rxDlc) && dlc0View[crb_pkg::BIT_RTR] == $past(remote_request_flag))
    else $error("Length register does not show received code");

  a_bus_answer: assert property (@(posedge clk) disable iff (reset)
    (read || write) && waitrequest_ff |=> !waitrequest_ff ##1 waitrequest_ff)
    else $error("Bus answer not one cycle after request");

endmodule // crb_receive_status

// ### rtl/crb_slot.sv
`timescale 1ns/1ps
module crb_slot (
  input wire logic clk,
  input wire logic reset,
  input wire logic load,
  input wire logic clearFull,
  input wire logic [crb_pkg::FILT_W-1:0] loadFilter,
  input wire logic [crb_pkg::DLC_W-1:0] loadDlc,
  input wire logic loadRtr,
  output logic full,
  output logic [crb_pkg::FILT_W-1:0] filter,
  output logic [crb_pkg::DLC_W-1:0] dlc,
  output logic rtr
);

  logic full_ff;
  logic [crb_pkg::FILT_W-1:0] filter_ff;
  logic [crb_pkg::DLC_W-1:0] dlc_ff;
  logic rtr_ff;

  // Load wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      full_ff <= 1'b0;
    end else begin
      full_ff <= load | (full_ff & ~clearFull);
    end
  end

  // Contents frozen while full
  always_ff @(posedge clk) begin
    if (reset) begin
      filter_ff <= '0;
      dlc_ff <= '0;
      rtr_ff <= 1'b0;
    end else if (load && !full_ff) begin
      filter_ff <= loadFilter;
      dlc_ff <= loadDlc;
      rtr_ff <= loadRtr;
    end
  end

  assign full = full_ff;
  assign filter = filter_ff;
  assign dlc = dlc_ff;
  assign rtr = rtr_ff;

  a_full_holds: assert property (@(posedge clk) disable iff (reset)
    full_ff && !clearFull |=> full_ff)
    else $error("Full flag dropped without a clear");

  a_no_overwrite: assert property (@(posedge clk) disable iff (reset)
    full_ff |=> $stable(dlc_ff) && $stable(filter_ff) && $stable(rtr_ff))
    else $error("Full buffer contents changed");

endmodule // crb_slot

// ### tb/crb_frame_src.sv
`timescale 1ns/1ps
// Far-side node: offers one received frame per send pulse
module crb_frame_src (
  input wire logic clk,
  input wire logic reset,
  input wire logic send,
  input wire logic [3:0] fIn,
  input wire logic [3:0] dIn,
  input wire logic rIn,
  output logic rxValid,
  output logic [3:0] rxFilter,
  output logic [3:0] rxDlc,
  output logic remote_request_flag
);
  always_ff @(posedge clk) begin
    if (reset) begin
      rxValid <= 1'b0;
    end else begin
      rxValid <= send;
    end
  end
  // Outside a frame the fields toggle so stale values never look valid
  always_ff @(posedge clk) begin
    if (reset) begin
      {rxFilter, rxDlc, remote_request_flag} <= '0;
    end else if (send) begin
      {rxFilter, rxDlc, remote_request_flag} <= {fIn, dIn, rIn};
    end else begin
      {rxFilter, rxDlc, remote_request_flag} <= ~{rxFilter, rxDlc, remote_request_flag};
    end
  end
endmodule // crb_frame_src

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 0, reset = 1, read = 0, write = 0, send = 0, rIn = 0;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h0, readdata, rs = 32'hCE20BD41;
  logic [3:0] fIn = 4'h0, dIn = 4'h0, rxFilter, rxDlc, byteenable = 4'hF;
  logic waitrequest, rxValid, remote_request_flag, irq;
  logic [31:0] q[$];
  int n_mismatch = 0, check_count = 0, cyc = 0;
  crb_receive_status uut (.clk(clk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .rxValid(rxValid), .rxFilter(rxFilter), .rxDlc(rxDlc),
    .remote_request_flag(remote_request_flag), .irq(irq));
  crb_frame_src src (.clk(clk), .reset(reset), .send(send), .fIn(fIn), .dIn(dIn),
    .rIn(rIn), .rxValid(rxValid), .rxFilter(rxFilter), .rxDlc(rxDlc), .remote_request_flag(remote_request_flag));
  initial begin
    forever #20 clk = ~clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      test_done;
    end
  end
  always @(posedge clk) begin
    if (read && waitrequest === 1'b0) chk(readdata, q.pop_front());
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= {24'h0, d};
    do @(posedge clk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task rd(input logic [4:0] a, input logic [7:0] e);
    q.push_back({24'h0, e});
    acc(1'b0, a, 8'h00);
  endtask
  task frm(input logic [3:0] f, input logic [3:0] d, input logic r);
    @(posedge clk);
    send <= 1'b1;
    fIn <= f;
    dIn <= d;
    rIn <= r;
    @(posedge clk);
    send <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task irqis(input logic e);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rd(crb_pkg::OFS_CTRL0, 8'h00);
    rd(crb_pkg::OFS_DLC0, 8'h00);
    rd(5'h1C, 8'h00);
    acc(1'b1, crb_pkg::OFS_CTRL0, 8'h04);
    rd(crb_pkg::OFS_CTRL0, 8'h06);
    acc(1'b1, crb_pkg::OFS_CTRL0, 8'h00);
    rd(crb_pkg::OFS_CTRL0, 8'h00);
    acc(1'b1, crb_pkg::OFS_MASK, 8'h01);
    byteenable <= 4'h0;
    acc(1'b1, crb_pkg::OFS_MASK, 8'h07);
    byteenable <= 4'hF;
    rd(crb_pkg::OFS_MASK, 8'h01);
    frm(4'h1, 4'h8, 1'b1);
    irqis(1'b1);
    rd(crb_pkg::OFS_CTRL0, 8'h81);
    rd(crb_pkg::OFS_DLC0, 8'h48);
    frm(4'h0, 4'h3, 1'b0);
    rd(crb_pkg::OFS_CTRL1, 8'h00);
    rd(crb_pkg::OFS_DLC0, 8'h48);
    rd(crb_pkg::OFS_STAT, 8'h05);
    acc(1'b1, crb_pkg::OFS_STAT, 8'h05);
    rd(crb_pkg::OFS_STAT, 8'h01);
    irqis(1'b1);
    acc(1'b1, crb_pkg::OFS_CTRL0, 8'h00);
    acc(1'b1, crb_pkg::OFS_STAT, 8'h01);
    rd(crb_pkg::OFS_STAT, 8'h00);
    irqis(1'b0);
    acc(1'b1, crb_pkg::OFS_CTRL0, 8'h04);
    frm(4'h2, 4'h5, 1'b0);
    rs = nx(rs);
    frm(rs[3:0], rs[7:4], rs[8]);
    rd(crb_pkg::OFS_CTRL0, 8'h86);
    rd(crb_pkg::OFS_CTRL1, {4'h8, rs[3:0]});
    rd(crb_pkg::OFS_DLC1, {1'b0, rs[8], 2'b00, rs[7:4]});
    rd(crb_pkg::OFS_STAT, 8'h03);
    acc(1'b1, crb_pkg::OFS_CTRL0, 8'h00);
    acc(1'b1, crb_pkg::OFS_CTRL1, 8'h00);
    for (int m = 1; m < 4; m++) begin
      acc(1'b1, crb_pkg::OFS_MODE, m[7:0]);
      rd(crb_pkg::OFS_MODE, m[7:0]);
      for (int k = 0; k < 4; k++) begin
        rs = nx(rs);
        if (k == 3) rs[3:0] = 4'hF;
        frm(rs[3:0], rs[7:4], 1'b0);
        rd(crb_pkg::OFS_CTRL0, {4'h8, rs[3:0]});
        acc(1'b1, crb_pkg::OFS_CTRL0, 8'h00);
      end
    end
    test_done;
  end
endmodule // tb
